// *** hw/sdc_core.sv ***
// Synchronous DRAM command layer: decode, banks, bursts, refresh, array
`timescale 1ns/10ps
module sdc_core (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  // Command strobes
  input  wire logic                         csN,
  input  wire logic                         rasN,
  input  wire logic                         casN,
  input  wire logic                         weN,
  input  wire logic                         cke,
  // Bank and address
  input  wire logic                         bankSelectLo,
  input  wire logic                         bankSelectHi,
  input  wire logic [sdc_pkg::ADDR_W-1:0]   addr,
  // Data and byte mask
  input  wire logic [sdc_pkg::LANES-1:0]    byteMask,
  input  wire logic [sdc_pkg::DQ_W-1:0]     dqIn,
  output logic [sdc_pkg::DQ_W-1:0]          dqOut,
  output logic [sdc_pkg::LANES-1:0]         dqOe,
  // Status
  output logic [sdc_pkg::ADDR_W-1:0]        modeReg,
  output logic [sdc_pkg::ADDR_W-1:0]        refreshRow,
  output logic                              selfRefresh,
  output logic                              wrBufReady
);
  import sdc_pkg::*;

  localparam int MEM_WORDS = 1 << (BANK_W + ADDR_W + COL_W);
  localparam int NBANK = 1 << BANK_W;

  // Column mask of a burst for the programmed length
  function automatic logic [COL_W-1:0] burstMask(input logic [ADDR_W-1:0] mode);
    logic [2:0] bl;
    bl = mode[MODE_BL_LSB +: 3];
    unique case (bl)
      3'h0:    burstMask = 8'h00;
      3'h1:    burstMask = 8'h01;
      3'h2:    burstMask = 8'h03;
      3'h3:    burstMask = 8'h07;
      BL_FULL: burstMask = 8'hFF;
      default: burstMask = 8'h00;
    endcase
  endfunction : burstMask

  // Next column, wrapping inside the burst block
  function automatic logic [COL_W-1:0] nextCol(input logic [COL_W-1:0] col,
                                               input logic [COL_W-1:0] msk);
    nextCol = (col & ~msk) | ((col + 8'h01) & msk);
  endfunction : nextCol

  // Array index from bank, row and column
  function automatic logic [BANK_W+ADDR_W+COL_W-1:0] memIdx(input logic [BANK_W-1:0] b,
                                                           input logic [ADDR_W-1:0] r,
                                                           input logic [COL_W-1:0] c);
    memIdx = {b, r, c};
  endfunction : memIdx

  logic [DQ_W-1:0]    mem [0:MEM_WORDS-1];    // Storage array
  logic [ADDR_W-1:0]  modeReg_q;               // Mode register
  logic [ADDR_W-1:0]  rowCnt_q;                // Refresh row counter
  logic [CNT_W-1:0]   refCnt_q;                // Refresh busy timer
  logic [CNT_W-1:0]   pwrCnt_q;                // Self tick or exit timer
  sdc_pwr_t           pwr_q;                   // Power state
  logic               selfRefresh_q;
  logic [NBANK-1:0]   open_q;                  // Row open per bank
  logic [ADDR_W-1:0]  row_q [0:NBANK-1];       // Open row per bank
  logic [CNT_W-1:0]   pchgCnt_q [0:NBANK-1];   // Precharge timer per bank
  sdc_burst_t         burst_q;                 // Burst in progress
  logic [BANK_W-1:0]  bBank_q;
  logic [COL_W-1:0]   bCol_q;
  logic [COL_W:0]     bLeft_q;                 // Beats still to go
  logic               bFull_q;                 // Full-page burst
  logic               bAp_q;                   // Auto precharge pending
  logic [RD_STAGES-1:0]            rdV_q;      // Read pipe valid
  logic [RD_STAGES-1:0][DQ_W-1:0]  rdD_q;      // Read pipe data, stage 0 drives out
  logic [LANES-1:0]   maskD_q;                 // Mask seen one clock ago
  logic [LANES-1:0]   dqOe_q;
  logic               wrBufReady_q;

  // Decode signals
  logic [2:0]         cmdCode;
  logic [BANK_W-1:0]  bank;
  logic               cmdSel;
  logic               allIdle;
  logic               isAct;
  logic               isRd;
  logic               isWr;
  logic               isBst;
  logic               isPre;
  logic               isRef;
  logic               isMrs;
  logic               selfEntry;
  logic               stopNow;
  logic [COL_W-1:0]   msk;
  // Beat signals
  logic               beatGo;
  logic               beatWr;
  logic               beatLast;
  logic               beatAp;
  logic [BANK_W-1:0]  beatBank;
  logic [COL_W-1:0]   beatCol;
  logic [DQ_W-1:0]    memRd;
  logic [1:0]         clIdx;
  logic [RD_STAGES-1:0]           rdNextV;
  logic [RD_STAGES-1:0][DQ_W-1:0] rdNextD;
  // Write buffer
  logic               bufInRdy;
  logic               bufOutVal;
  logic               bufOutRdy;
  logic [WBUF_W-1:0]  bufOut;
  logic [BANK_W-1:0]  wbBank;
  logic [ADDR_W-1:0]  wbRow;
  logic [COL_W-1:0]   wbCol;
  logic [DQ_W-1:0]    wbData;
  logic [LANES-1:0]   wbMask;

  assign cmdCode = {rasN, casN, weN};
  assign bank    = {bankSelectHi, bankSelectLo};
  assign msk     = burstMask(modeReg_q);

  // All banks idle, no refresh and no burst running
  always_comb begin
    allIdle = (refCnt_q == '0) && (burst_q == BURST_IDLE);
    for (int i = 0; i < NBANK; i++) begin
      if (open_q[i] || pchgCnt_q[i] != '0) begin
        allIdle = 1'b0;
      end
    end
  end

  assign cmdSel = !csN && cke && (pwr_q == PWR_NORMAL) && (refCnt_q == '0);
  assign isAct = cmdSel && cmdCode == CMD_ACT && !open_q[bank] && pchgCnt_q[bank] == '0;
  assign isRd  = cmdSel && cmdCode == CMD_RD && open_q[bank];
  assign isWr  = cmdSel && cmdCode == CMD_WR && open_q[bank];
  assign isBst = cmdSel && cmdCode == CMD_BST;
  assign isPre = cmdSel && cmdCode == CMD_PRE;
  assign isRef = cmdSel && cmdCode == CMD_REF && allIdle;
  assign isMrs = cmdSel && cmdCode == CMD_MRS && allIdle;
  assign selfEntry = !csN && !cke && cmdCode == CMD_REF && pwr_q == PWR_NORMAL && allIdle;
  assign stopNow = isBst || (isPre && (addr[AUTO_PRECHARGE_BIT] || bank == bBank_q));

  // One data beat per clock while a burst runs
  always_comb begin
    beatGo   = 1'b0;
    beatWr   = 1'b0;
    beatBank = bBank_q;
    beatCol  = bCol_q;
    beatAp   = bAp_q;
    beatLast = !bFull_q && bLeft_q == (COL_W+1)'(1);
    if (isRd || isWr) begin
      beatGo   = 1'b1;
      beatWr   = isWr;
      beatBank = bank;
      beatCol  = addr[COL_W-1:0];
      beatAp   = addr[AUTO_PRECHARGE_BIT];
      beatLast = msk == '0 && modeReg_q[MODE_BL_LSB +: 3] != BL_FULL;
    end else if (burst_q != BURST_IDLE && !stopNow && cke) begin
      beatGo = 1'b1;
      beatWr = burst_q == BURST_WRITE;
    end
  end

  assign memRd = mem[memIdx(beatBank, row_q[beatBank], beatCol)];

  // Burst tracking
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      burst_q <= BURST_IDLE;
      bBank_q <= '0;
      bCol_q  <= '0;
      bLeft_q <= '0;
      bFull_q <= 1'b0;
      bAp_q   <= 1'b0;
    end else if (isRd || isWr) begin
      // A new access replaces any burst in flight
      burst_q <= beatLast ? BURST_IDLE : (isWr ? BURST_WRITE : BURST_READ);
      bBank_q <= bank;
      bCol_q  <= nextCol(addr[COL_W-1:0], msk);
      bLeft_q <= {1'b0, msk};
      bFull_q <= modeReg_q[MODE_BL_LSB +: 3] == BL_FULL;
      bAp_q   <= addr[AUTO_PRECHARGE_BIT];
    end else if (stopNow) begin
      burst_q <= BURST_IDLE;
    end else if (beatGo) begin
      bCol_q  <= nextCol(bCol_q, msk);
      bLeft_q <= bLeft_q - 1'b1;
      if (beatLast) begin
        burst_q <= BURST_IDLE;
      end
    end
  end

  // Bank rows and precharge timers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      open_q <= '0;
      for (int i = 0; i < NBANK; i++) begin
        row_q[i]     <= '0;
        pchgCnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NBANK; i++) begin
        if (pchgCnt_q[i] != '0) begin
          pchgCnt_q[i] <= pchgCnt_q[i] - 1'b1;
        end
        if (isPre && (addr[AUTO_PRECHARGE_BIT] || bank == BANK_W'(i))) begin
          open_q[i]    <= 1'b0;
          pchgCnt_q[i] <= PCHG_CYC;
        end
        if (beatGo && beatLast && beatAp && beatBank == BANK_W'(i)) begin
          open_q[i]    <= 1'b0;
          pchgCnt_q[i] <= PCHG_CYC;
        end
      end
      if (isAct) begin
        open_q[bank] <= 1'b1;
        row_q[bank]  <= addr;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      modeReg_q <= MODE_RST;
    end else if (isMrs) begin
      modeReg_q <= addr;
    end
  end

  // Refresh counter, auto refresh timer and power state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rowCnt_q      <= '0;
      refCnt_q      <= '0;
      pwrCnt_q      <= '0;
      pwr_q         <= PWR_NORMAL;
      selfRefresh_q <= 1'b0;
    end else begin
      if (refCnt_q != '0) begin
        refCnt_q <= refCnt_q - 1'b1;
      end
      unique case (pwr_q)
        PWR_NORMAL: begin
          if (isRef) begin
            rowCnt_q <= rowCnt_q + 1'b1;
            refCnt_q <= REF_CYC;
          end else if (selfEntry) begin
            pwr_q         <= PWR_SELF;
            pwrCnt_q      <= '0;
            selfRefresh_q <= 1'b1;
          end
        end
        PWR_SELF: begin
          if (cke) begin
            pwr_q         <= PWR_EXIT;
            pwrCnt_q      <= XSR_CYC;
            selfRefresh_q <= 1'b0;
          end else if (pwrCnt_q == SELF_TICK_CYC - 1'b1) begin
            pwrCnt_q <= '0;
            rowCnt_q <= rowCnt_q + 1'b1;
          end else begin
            pwrCnt_q <= pwrCnt_q + 1'b1;
          end
        end
        PWR_EXIT: begin
          if (pwrCnt_q <= CNT_W'(1)) begin
            pwr_q <= PWR_NORMAL;
          end
          pwrCnt_q <= pwrCnt_q - 1'b1;
        end
        default: begin
          pwr_q <= PWR_NORMAL;
        end
      endcase
    end
  end

  // Latency stage index from the programmed latency
  always_comb begin
    unique case (modeReg_q[MODE_CL_LSB +: 3])
      3'h1:    clIdx = 2'h0;
      3'h2:    clIdx = 2'h1;
      default: clIdx = 2'h2;
    endcase
  end

  // Read pipe shifts toward stage 0; a fetch enters at the latency slot
  always_comb begin
    rdNextV = {1'b0, rdV_q[RD_STAGES-1:1]};
    rdNextD = {{DQ_W{1'b0}}, rdD_q[RD_STAGES-1:1]};
    if (beatGo && !beatWr) begin
      rdNextV[clIdx] = 1'b1;
      rdNextD[clIdx] = memRd;
    end
  end

  // Read pipe and output drivers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdV_q   <= '0;
      rdD_q   <= '0;
      maskD_q <= '1;
      dqOe_q  <= '0;
    end else begin
      rdV_q   <= rdNextV;
      rdD_q   <= rdNextD;
      maskD_q <= byteMask;
      // read mask acts two clocks later
      dqOe_q  <= rdNextV[0] ? ~maskD_q : '0;
    end
  end

  // Buffer status register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrBufReady_q <= 1'b0;
    end else begin
      wrBufReady_q <= bufInRdy;
    end
  end

  // Array has one port: a read fetch stalls the drain
  assign bufOutRdy = !(beatGo && !beatWr);
  assign {wbBank, wbRow, wbCol, wbData, wbMask} = bufOut;

  sdc_fifo #(
    .WIDTH (WBUF_W),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .inValid  (beatGo && beatWr),
    .inReady  (bufInRdy),
    .inData   ({beatBank, row_q[beatBank], beatCol, dqIn, byteMask}),
    .outValid (bufOutVal),
    .outReady (bufOutRdy),
    .outData  (bufOut)
  );

  // Drain buffered writes into the array
  always_ff @(posedge clk_sys) begin
    if (bufOutVal && bufOutRdy) begin
      for (int b = 0; b < LANES; b++) begin
        if (!wbMask[b]) begin
          mem[memIdx(wbBank, wbRow, wbCol)][8*b +: 8] <= wbData[8*b +: 8];
        end
      end
    end
  end

  assign dqOut      = rdD_q[0];
  assign dqOe       = dqOe_q;
  assign modeReg    = modeReg_q;
  assign refreshRow = rowCnt_q;
  assign selfRefresh = selfRefresh_q;
  assign wrBufReady = wrBufReady_q;
endmodule : sdc_core

// *** hw/sdc_pkg.sv ***
// Shared constants and types for the synchronous DRAM command layer
package sdc_pkg;
  // Bus widths
  localparam int BANK_W  = 2;
  localparam int ADDR_W  = 12;
  localparam int COL_W   = 8;
  localparam int DQ_W    = 32;
  localparam int LANES   = 4;
  localparam int CNT_W   = 9;
  localparam int RD_STAGES = 3;
  // Command codes as {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  // Address and mode field positions
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h020;
  // Timing in ns and derived cycle counts at the 40 ns clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int REFRESH_CYCLE_TIME_NS = 70;
  localparam int SELF_REFRESH_EXIT_TIME_NS = 70;
  localparam int SELF_REFRESH_EXIT_MIN_CYC = 2;
  localparam int SELF_TICK_NS = 15625;
  localparam logic [CNT_W-1:0] PCHG_CYC = CNT_W'((PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] REF_CYC = CNT_W'((REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1)
                                                / CLK_PERIOD_NS);
  localparam int XSR_RAW = (SELF_REFRESH_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] XSR_CYC = CNT_W'((XSR_RAW > SELF_REFRESH_EXIT_MIN_CYC) ?
                                                XSR_RAW : SELF_REFRESH_EXIT_MIN_CYC);
  localparam logic [CNT_W-1:0] SELF_TICK_CYC = CNT_W'(SELF_TICK_NS / CLK_PERIOD_NS);
  // Write buffer entry: bank, row, column, data, mask
  localparam int WBUF_DEPTH = 8;
  localparam int WBUF_W = BANK_W + ADDR_W + COL_W + DQ_W + LANES;
  // Burst and power states
  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sdc_burst_t;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_SELF, PWR_EXIT} sdc_pwr_t;
endpackage : sdc_pkg

// *** hw/sdc_fifo.sv ***
// Write buffer FIFO with valid and ready on both sides
`timescale 1ns/10ps
module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];  // Entry storage
  logic [PTR_W-1:0] wrPtr_q;            // Next slot to fill
  logic [PTR_W-1:0] rdPtr_q;            // Oldest entry
  logic [PTR_W:0]   count_q;            // Entries held
  logic             push;
  logic             pop;

  assign inReady  = count_q != (PTR_W+1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData  = store[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Store data on push
  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : sdc_fifo

// *** testbench/sdc_core_chk.sv ***
// Port checker for the DRAM command layer
`timescale 1ns/10ps
module sdc_core_chk (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       resetn,
  // Command pins
  input wire logic                       csN,
  input wire logic                       rasN,
  input wire logic                       casN,
  input wire logic                       weN,
  input wire logic                       cke,
  input wire logic [sdc_pkg::ADDR_W-1:0] addr,
  input wire logic [sdc_pkg::LANES-1:0]  byteMask,
  // Outputs watched
  input wire logic [sdc_pkg::LANES-1:0]  dqOe,
  input wire logic [sdc_pkg::ADDR_W-1:0] modeReg,
  input wire logic [sdc_pkg::ADDR_W-1:0] refreshRow,
  input wire logic                       selfRefresh
);
  import sdc_pkg::*;
  logic [2:0] cmd; // Strobe code
  logic       sel; // Chip selected
  assign cmd = {rasN, casN, weN};
  assign sel = !csN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // mode changes only on mode load
  chk_mode_cause: assert property ($changed(modeReg) |-> $past(sel && cke && cmd == CMD_MRS))
    else $error("mode register changed without mode load");
  chk_mode_value: assert property ($changed(modeReg) |-> modeReg == $past(addr))
    else $error("mode register value differs from address");
  chk_read_mask: assert property (|dqOe |-> (dqOe & $past(byteMask, 2)) == 4'h0)
    else $error("masked lane driven");
  chk_self_entry: assert property ($rose(selfRefresh) |-> $past(sel && !cke && cmd == CMD_REF))
    else $error("self refresh entered without command");
  chk_self_stay: assert property (selfRefresh && !cke |=> selfRefresh)
    else $error("self refresh left with clock enable low");
  chk_self_exit: assert property (selfRefresh && cke |-> ##[1:2] !selfRefresh)
    else $error("self refresh not left");
  chk_row_step: assert property ($changed(refreshRow) |-> refreshRow == $past(refreshRow) + 12'h001)
    else $error("refresh row jumped");
  // refresh row advances only by refresh
  chk_row_cause: assert property ($changed(refreshRow) |-> selfRefresh || $past(selfRefresh, 2)
      || $past(sel && cke && cmd == CMD_REF) || $past(sel && cke && cmd == CMD_REF, 2))
    else $error("refresh row moved without refresh");
  // no read data in self refresh
  chk_self_quiet: assert property (selfRefresh && $past(selfRefresh, 3) |-> dqOe == 4'h0)
    else $error("data driven in self refresh");
  cover property ($rose(selfRefresh));
  cover property (|dqOe ##1 |dqOe);
  cover property ($changed(refreshRow));
endmodule : sdc_core_chk

// *** testbench/sdc_ctrl_model.sv ***
// Controller model driving the DRAM command and write data pins
`timescale 1ns/10ps
module sdc_ctrl_model (
  // Clock
  input wire logic                   clk_sys,
  // Command pins
  output logic                       csN,
  output logic                       rasN,
  output logic                       casN,
  output logic                       weN,
  output logic                       cke,
  // Bank, address, mask, data
  output logic                       bankSelectLo,
  output logic                       bankSelectHi,
  output logic [sdc_pkg::ADDR_W-1:0] addr,
  output logic [sdc_pkg::LANES-1:0]  byteMask,
  output logic [sdc_pkg::DQ_W-1:0]   dqIn
);
  import sdc_pkg::*;
  logic ckeLvl = 1'b1; // Clock enable for next cycle
  // Deselected idle bus at time zero
  initial begin
    {csN, rasN, casN, weN, cke, bankSelectHi, bankSelectLo} = 7'h7F;
    addr = 12'h000;
    byteMask = 4'h0;
    dqIn = 32'h0;
  end
  // one command after the falling edge
  task automatic cmd(input logic s, input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [31:0] d, input logic [3:0] m);
    @(negedge clk_sys);
    csN = s;
    {rasN, casN, weN} = c;
    cke = ckeLvl;
    {bankSelectHi, bankSelectLo} = b;
    addr = a;
    dqIn = d;
    byteMask = m;
  endtask : cmd
  // No-op; unused lines flip to their inverse
  task automatic nop(input logic [3:0] m);
    cmd(1'b0, CMD_NOP, ~{bankSelectHi, bankSelectLo}, ~addr, ~dqIn, m);
  endtask : nop
  // mode load then two idle clocks
  task automatic modeLoad(input logic [11:0] a);
    cmd(1'b0, CMD_MRS, 2'h0, a, ~dqIn, 4'h0);
    repeat (2) nop(4'h0);
  endtask : modeLoad
  task automatic autoRef();
    cmd(1'b0, CMD_PRE, 2'h0, 12'h400, ~dqIn, 4'h0);
    repeat (2) nop(4'h0);
    cmd(1'b0, CMD_REF, 2'h0, ~addr, ~dqIn, 4'h0);
    repeat (REF_CYC + 1) nop(4'h0);
  endtask : autoRef
  task automatic exitSelf();
    ckeLvl = 1'b1;
    repeat (XSR_CYC + 2) nop(4'h0);
  endtask : exitSelf
endmodule : sdc_ctrl_model

// *** testbench/sdc_core_tb_top.sv ***
// Self-checking bench for the DRAM command layer
`timescale 1ns/10ps
module sdc_core_tb_top;
  import sdc_pkg::*;
  // Clock, reset, pins
  logic                clk_sys = 1'b0;
  logic                resetn = 1'b0;
  logic                csN, rasN, casN, weN, cke, bankSelectLo, bankSelectHi;
  logic                selfRefresh, wrBufReady;
  logic [ADDR_W-1:0]   addr, modeReg, refreshRow, r0;
  logic [LANES-1:0]    byteMask, dqOe;
  logic [DQ_W-1:0]     dqIn, dqOut;
  // Bench state
  int                  seed, failures, compares, stop;
  logic [DQ_W-1:0]     got[$];
  logic [DQ_W-1:0]     wd[4];
  logic [DQ_W-1:0]     ex[4][4];
  logic [LANES-1:0]    wm[4];
  logic [ADDR_W-1:0]   rw[4];
  logic [COL_W-1:0]    cl[4];
  // Clock
  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  sdc_ctrl_model ctl (.clk_sys(clk_sys), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .cke(cke), .bankSelectLo(bankSelectLo), .bankSelectHi(bankSelectHi), .addr(addr),
    .byteMask(byteMask), .dqIn(dqIn));
  sdc_core dut (.clk_sys(clk_sys), .resetn(resetn), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .cke(cke), .bankSelectLo(bankSelectLo), .bankSelectHi(bankSelectHi),
    .addr(addr), .byteMask(byteMask), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .modeReg(modeReg), .refreshRow(refreshRow), .selfRefresh(selfRefresh),
    .wrBufReady(wrBufReady));
  // Lane merge of old and new write data
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
    for (int i = 0; i < LANES; i++) o[8*i+:8] = m[i] ? o[8*i+:8] : n[8*i+:8];
    return o;
  endfunction : merge
  task automatic cmpData(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : cmpData
  task automatic cmpStat(input string n, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : cmpStat
  // Beat count and words of a read
  task automatic cmpBurst(input int b, input int n);
    cmpStat("beats", 12'(n), 12'(got.size()));
    foreach (got[i]) cmpData("word", ex[b][i], got[i]);
  endtask : cmpBurst
  // Four-beat write from wd and wm
  task automatic wr(input logic [1:0] b, input logic [7:0] c);
    ctl.cmd(1'b0, CMD_WR, b, {4'h0, c}, wd[0], wm[0]);
    for (int j = 1; j < 4; j++) ctl.cmd(1'b0, CMD_NOP, ~b, ~{4'h0, c}, wd[j], wm[j]);
    repeat (6) ctl.nop(4'h0);
  endtask : wr
  // Read, optional stop at cycle, collect driven beats
  task automatic rd(input logic [1:0] b, input logic [7:0] c, input logic ap,
                    input logic [3:0] m, input int st);
    got.delete();
    ctl.cmd(1'b0, CMD_RD, b, {1'b0, ap, 2'h0, c}, $random(seed), m);
    for (int i = 0; i < 10; i++) begin
      if (i == st) ctl.cmd(1'b0, CMD_BST, ~b, 12'hFFF, $random(seed), m);
      else ctl.nop(m);
      if (|dqOe) begin
        got.push_back(dqOut);
        cmpStat("oe", {8'h0, ~m}, {8'h0, dqOe});
      end
    end
  endtask : rd
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end
  // Main sequence
  initial begin
    seed = 85;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    cmpStat("mode", MODE_RST, modeReg);
    ctl.cmd(1'b1, CMD_MRS, 2'h0, 12'h03F, 32'h0, 4'h0);
    ctl.nop(4'h0);
    cmpStat("ready", 12'h001, {11'h0, wrBufReady});
    cmpStat("mode", MODE_RST, modeReg);
    ctl.modeLoad(12'h022);
    cmpStat("mode", 12'h022, modeReg);
    $display("test mode done");
    for (int b = 0; b < 4; b++) begin
      rw[b] = ADDR_W'($random(seed));
      cl[b] = COL_W'($random(seed)) & 8'hFC;
      ctl.cmd(1'b0, CMD_ACT, 2'(b), rw[b], $random(seed), 4'h0);
      ctl.nop(4'h0);
      for (int j = 0; j < 4; j++) begin
        wd[j] = $random(seed);
        wm[j] = 4'h0;
      end
      wr(2'(b), cl[b]);
      for (int j = 0; j < 4; j++) begin
        ex[b][j] = wd[j];
        wd[j] = $random(seed);
        wm[j] = (j == 3) ? 4'hF : LANES'($random(seed));
        ex[b][j] = merge(ex[b][j], wd[j], wm[j]);
      end
      wr(2'(b), cl[b]);
      rd(2'(b), cl[b], 1'b0, 4'h0, 99);
      cmpBurst(b, 4);
    end
    rd(2'h3, cl[3], 1'b0, 4'h5, 99);
    cmpStat("beats", 12'h004, 12'(got.size()));
    stop = $unsigned($random(seed)) % 3;
    rd(2'h3, cl[3], 1'b0, 4'h0, stop);
    cmpBurst(3, stop + 1);
    $display("test burst done");
    rd(2'h2, cl[2], 1'b1, 4'h0, 99);
    cmpBurst(2, 4);
    rd(2'h2, cl[2], 1'b0, 4'h0, 99);
    cmpStat("beats", 12'h000, 12'(got.size()));
    ctl.cmd(1'b0, CMD_ACT, 2'h2, rw[2], $random(seed), 4'h0);
    ctl.nop(4'h0);
    rd(2'h2, cl[2], 1'b0, 4'h0, 99);
    cmpBurst(2, 4);
    ctl.cmd(1'b0, CMD_PRE, 2'h0, 12'h000, 32'h0, 4'h0);
    ctl.nop(4'h0);
    rd(2'h1, cl[1], 1'b0, 4'h0, 99);
    cmpBurst(1, 4);
    rd(2'h0, cl[0], 1'b0, 4'h0, 99);
    cmpStat("beats", 12'h000, 12'(got.size()));
    ctl.cmd(1'b0, CMD_PRE, 2'h0, 12'h400, 32'h0, 4'h0);
    ctl.nop(4'h0);
    rd(2'h1, cl[1], 1'b0, 4'h0, 99);
    cmpStat("beats", 12'h000, 12'(got.size()));
    // Full-page burst at latency three, cut after four beats
    ctl.modeLoad(12'h037);
    cmpStat("mode", 12'h037, modeReg);
    ctl.cmd(1'b0, CMD_ACT, 2'h1, rw[1], $random(seed), 4'h0);
    ctl.nop(4'h0);
    rd(2'h1, cl[1], 1'b0, 4'h0, 3);
    cmpBurst(1, 4);
    $display("test precharge done");
    r0 = refreshRow;
    ctl.autoRef();
    cmpStat("row", r0 + 12'h001, refreshRow);
    ctl.ckeLvl = 1'b0;
    ctl.cmd(1'b0, CMD_REF, 2'h0, ADDR_W'($random(seed)), $random(seed), 4'h0);
    repeat (6) ctl.cmd(1'b0, CMD_MRS, 2'h0, ADDR_W'($random(seed)), $random(seed), 4'h0);
    cmpStat("self", 12'h001, {11'h0, selfRefresh});
    cmpStat("mode", 12'h037, modeReg);
    ctl.exitSelf();
    cmpStat("self", 12'h000, {11'h0, selfRefresh});
    ctl.autoRef();
    $display("test refresh done");
    summarize();
  end
endmodule : sdc_core_tb_top
bind sdc_core sdc_core_chk chk (.clk_sys(clk_sys), .resetn(resetn), .csN(csN), .rasN(rasN),
  .casN(casN), .weN(weN), .cke(cke), .addr(addr), .byteMask(byteMask), .dqOe(dqOe),
  .modeReg(modeReg), .refreshRow(refreshRow), .selfRefresh(selfRefresh));
